// ==== verilog/dual_comparator_control.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Result is high when non-inverting input exceeds inverting input.
// - Three-bit mode field selects one of eight pin arrangements.
// - Pins in analog role read as zero on port reads.
// - Comparator output pins carry the result over the port value.
// - Result bits in the configuration register are always readable.
// - Results drive output pins only in mode 110.
// - Invert bit complements each comparator result.
// - Switch bit picks inverting pin: C1 in mode 001, both in 010.
// - Both candidate inverting pins stay analog in switchable modes.
// - Change flag sets when the result changes between two latches.
// - Reference latch captures result on every configuration read.
// - Sample latch takes result every cycle; differing latches mismatch.
// - Flag held set while mismatch lasts; read or revert ends it.
// - Configuration writes also update the reference latch.
// - Flag stays until software writes 0; writing 1 sets it.
// - Interrupt needs per-comparator, peripheral and global enables.
// - Clearing the flag has no effect while mismatch is active.
// - Only comparator two reaches the timer gate.
// - Both comparators share one mode setting.
// - Mode 000 off with analog pins; 111 off with digital pins.
// - Reset returns configuration registers to reset values, mode 000.
// - Gate select 0 takes comparator two, 1 takes gate pin.
// - With sync on, comparator two latched on timer clock falling edge.
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire cmp_ctrl_pkg::reg_req_s req,
  output logic [7:0] rdata,
  // Raw analog comparator decisions, one per comparator
  input wire logic [1:0] cmp_raw,
  // Analog pin control and output pin drive
  output cmp_ctrl_pkg::pin_ctrl_s pin_ctrl,
  // Port read masking for the four shared pins
  input wire logic [3:0] port_in,
  output logic [3:0] port_read,
  // Timer gate link
  input wire logic gate_pin,
  input wire logic timer_clk,
  output logic timer_gate,
  // Interrupt request to the processor
  output logic irq
);
  import cmp_ctrl_pkg::*;

  cmp_state_s st_reg;
  cmp_state_s st_next;
  cmp_mode_e mode;
  logic [1:0] result;
  logic [1:0] mismatch;
  logic cfg_touch;

  assign mode = cmp_mode_e'(st_reg.config_r[MODE_LSB +: 3]);
  assign cfg_touch = (req.rd || req.wr) && req.addr == ADDR_CONFIG;

  // Comparators switched off report a steady low result.
  always_comb begin
    result[0] = pin_ctrl.cmp_on[0] & (st_reg.raw_s2[0] ^ st_reg.config_r[INV1_BIT]);
    result[1] = pin_ctrl.cmp_on[1] & (st_reg.raw_s2[1] ^ st_reg.config_r[INV2_BIT]);
  end

  assign mismatch = st_reg.samp_latch ^ st_reg.ref_latch;

  always_comb begin
    pin_ctrl = '0;
    case (mode)
      MODE_OFF_ANALOG: begin
        pin_ctrl.pin_analog = 4'hf;
      end
      MODE_THREE_MUX: begin
        pin_ctrl.pin_analog = 4'hf;
        pin_ctrl.cmp_on = 2'h3;
        pin_ctrl.c1_neg_alt = st_reg.config_r[SWITCH_BIT];
      end
      MODE_FOUR_MUX: begin
        pin_ctrl.pin_analog = 4'hf;
        pin_ctrl.cmp_on = 2'h3;
        pin_ctrl.c1_neg_alt = st_reg.config_r[SWITCH_BIT];
        pin_ctrl.c2_neg_alt = st_reg.config_r[SWITCH_BIT];
      end
      MODE_COMMON_REF: begin
        pin_ctrl.pin_analog = 4'hd;
        pin_ctrl.cmp_on = 2'h3;
      end
      MODE_INDEPENDENT: begin
        pin_ctrl.pin_analog = 4'hf;
        pin_ctrl.cmp_on = 2'h3;
      end
      MODE_ONE_INDEP: begin
        pin_ctrl.pin_analog = 4'h3;
        pin_ctrl.cmp_on = 2'h2;
      end
      MODE_COMMON_OUT: begin
        pin_ctrl.pin_analog = 4'hd;
        pin_ctrl.cmp_on = 2'h3;
        pin_ctrl.out_pin_en = 2'h3;
      end
      MODE_OFF_DIGITAL: begin
        pin_ctrl.pin_analog = 4'h0;
      end
      default: begin
        pin_ctrl.pin_analog = 4'hf;
      end
    endcase
    pin_ctrl.out_pin_val = st_reg.samp_latch & pin_ctrl.out_pin_en;
  end

  assign port_read = port_in & ~pin_ctrl.pin_analog;

  always_comb begin
    logic [7:0] flags;
    logic [1:0] cflag;
    st_next = st_reg;
    flags = st_reg.pflag;
    st_next.raw_s1 = cmp_raw;
    st_next.raw_s2 = st_reg.raw_s1;
    st_next.gate_s1 = gate_pin;
    st_next.gate_s2 = st_reg.gate_s1;
    st_next.tclk_s1 = timer_clk;
    st_next.tclk_s2 = st_reg.tclk_s1;
    st_next.tclk_d = st_reg.tclk_s2;
    st_next.samp_latch = result;
    if (cfg_touch) begin
      st_next.ref_latch = st_reg.samp_latch;
    end
    if (req.wr) begin
      case (req.addr)
        ADDR_CONFIG: begin
          st_next.config_r = (req.wdata & CONFIG_WMASK) | (st_reg.config_r & ~CONFIG_WMASK);
        end
        ADDR_TIMER_LINK: begin
          st_next.link = req.wdata & LINK_WMASK;
        end
        ADDR_IRQ_CONTROL: begin
          st_next.irq_ctl = req.wdata;
        end
        ADDR_PERIPH_ENABLE: begin
          st_next.pen = req.wdata;
        end
        ADDR_PERIPH_FLAGS: begin
          flags = req.wdata;
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over a software clear, and a live mismatch holds it.
    cflag = {flags[C2_FLAG_BIT], flags[C1_FLAG_BIT]} | mismatch;
    flags[C1_FLAG_BIT] = cflag[0];
    flags[C2_FLAG_BIT] = cflag[1];
    st_next.pflag = flags;
    st_next.config_r[RES1_BIT] = st_reg.samp_latch[0];
    st_next.config_r[RES2_BIT] = st_reg.samp_latch[1];
    // Falling edge of the synchronised timer clock captures comparator two.
    if (st_reg.tclk_d && !st_reg.tclk_s2) begin
      st_next.c2_synced = st_reg.samp_latch[1];
    end
    if (st_reg.link[GATE_SEL_BIT]) begin
      st_next.timer_gate = st_reg.gate_s2;
    end else if (st_reg.link[SYNC_BIT]) begin
      st_next.timer_gate = st_reg.c2_synced;
    end else begin
      st_next.timer_gate = st_reg.samp_latch[1];
    end
    st_next.irq = st_reg.irq_ctl[GLOBAL_EN_BIT] && st_reg.irq_ctl[PERIPH_EN_BIT] &&
                  |(st_reg.pflag & st_reg.pen & 8'h18);
    st_next.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_CONFIG: st_next.rdata = st_reg.config_r;
        ADDR_TIMER_LINK: st_next.rdata = st_reg.link;
        ADDR_IRQ_CONTROL: st_next.rdata = st_reg.irq_ctl;
        ADDR_PERIPH_ENABLE: st_next.rdata = st_reg.pen;
        ADDR_PERIPH_FLAGS: st_next.rdata = st_reg.pflag;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.config_r <= RST_CONFIG;
      st_reg.link <= RST_TIMER_LINK;
      st_reg.irq_ctl <= RST_IRQ_CONTROL;
      st_reg.pen <= RST_PERIPH_ENABLE;
      st_reg.pflag <= RST_PERIPH_FLAGS;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign irq = st_reg.irq;
  assign timer_gate = st_reg.timer_gate;

  property p_flag_on_mismatch;
    @(posedge ref_clk) disable iff (!resetn)
      mismatch[0] |=> st_reg.pflag[C1_FLAG_BIT];
  endproperty
  a_flag_on_mismatch: assert property (p_flag_on_mismatch) else $error("flag one missed a change");
  property p_ref_capture;
    @(posedge ref_clk) disable iff (!resetn) cfg_touch |=> st_reg.ref_latch == $past(st_reg.samp_latch);
  endproperty
  a_ref_capture: assert property (p_ref_capture) else $error("reference latch not updated");
  property p_ref_hold;
    @(posedge ref_clk) disable iff (!resetn) !cfg_touch |=> $stable(st_reg.ref_latch);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference latch moved without access");
  property p_clear_blocked;
    @(posedge ref_clk) disable iff (!resetn)
      (req.wr && req.addr == ADDR_PERIPH_FLAGS && mismatch[1]) |=> st_reg.pflag[C2_FLAG_BIT];
  endproperty
  a_clear_blocked: assert property (p_clear_blocked) else $error("flag cleared during mismatch");
  property p_irq_gate;
    @(posedge ref_clk) disable iff (!resetn) !st_reg.irq_ctl[GLOBAL_EN_BIT] |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
  property p_out_pins;
    @(posedge ref_clk) disable iff (!resetn) mode != MODE_COMMON_OUT |-> pin_ctrl.out_pin_en == 2'h0;
  endproperty
  a_out_pins: assert property (p_out_pins) else $error("output pins driven outside mode 110");
  property p_analog_read;
    @(posedge ref_clk) disable iff (!resetn) mode == MODE_OFF_ANALOG |-> port_read == 4'h0;
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("analog pin read nonzero");
  property p_gate_pin;
    @(posedge ref_clk) disable iff (!resetn)
      st_reg.link[GATE_SEL_BIT] |=> timer_gate == $past(st_reg.gate_s2);
  endproperty
  a_gate_pin: assert property (p_gate_pin) else $error("gate pin not routed");
  property p_sw_set;
    @(posedge ref_clk) disable iff (!resetn)
      (req.wr && req.addr == ADDR_PERIPH_FLAGS && req.wdata[C1_FLAG_BIT]) |=> st_reg.pflag[C1_FLAG_BIT];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set of flag lost");
  property p_flag2_on_mismatch;
    @(posedge ref_clk) disable iff (!resetn)
      mismatch[1] |=> st_reg.pflag[C2_FLAG_BIT];
  endproperty
  a_flag2_on_mismatch: assert property (p_flag2_on_mismatch) else $error("flag two missed a change");
  property p_samp_follow;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> st_reg.samp_latch == $past(result);
  endproperty
  a_samp_follow: assert property (p_samp_follow) else $error("sample latch missed a cycle");
  property p_res1;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> st_reg.config_r[RES1_BIT] == $past(st_reg.samp_latch[0]);
  endproperty
  a_res1: assert property (p_res1) else $error("result one bit stale");
  property p_res2;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> st_reg.config_r[RES2_BIT] == $past(st_reg.samp_latch[1]);
  endproperty
  a_res2: assert property (p_res2) else $error("result two bit stale");
  property p_irq_set;
    @(posedge ref_clk) disable iff (!resetn)
      (st_reg.irq_ctl[GLOBAL_EN_BIT] && st_reg.irq_ctl[PERIPH_EN_BIT] &&
       st_reg.pflag[C2_FLAG_BIT] && st_reg.pen[C2_FLAG_BIT]) |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled flag gave no irq");
  property p_irq_periph;
    @(posedge ref_clk) disable iff (!resetn)
      !st_reg.irq_ctl[PERIPH_EN_BIT] |=> !irq;
  endproperty
  a_irq_periph: assert property (p_irq_periph) else $error("irq without peripheral enable");
  property p_irq_local;
    @(posedge ref_clk) disable iff (!resetn)
      !((st_reg.pflag[C1_FLAG_BIT] && st_reg.pen[C1_FLAG_BIT]) ||
        (st_reg.pflag[C2_FLAG_BIT] && st_reg.pen[C2_FLAG_BIT])) |=> !irq;
  endproperty
  a_irq_local: assert property (p_irq_local) else $error("irq without enabled flag");
  property p_analog_mask;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> (port_read & pin_ctrl.pin_analog) == 4'h0;
  endproperty
  a_analog_mask: assert property (p_analog_mask) else $error("analog pin leaked to port read");
  property p_off_digital;
    @(posedge ref_clk) disable iff (!resetn)
      mode == MODE_OFF_DIGITAL |-> pin_ctrl.pin_analog == 4'h0 && pin_ctrl.cmp_on == 2'h0;
  endproperty
  a_off_digital: assert property (p_off_digital) else $error("digital off mode wrong");
  property p_off_analog;
    @(posedge ref_clk) disable iff (!resetn)
      mode == MODE_OFF_ANALOG |-> pin_ctrl.pin_analog == 4'hf && pin_ctrl.cmp_on == 2'h0;
  endproperty
  a_off_analog: assert property (p_off_analog) else $error("analog off mode wrong");
  property p_out_val;
    @(posedge ref_clk) disable iff (!resetn)
      mode == MODE_COMMON_OUT |-> pin_ctrl.out_pin_val == st_reg.samp_latch;
  endproperty
  a_out_val: assert property (p_out_val) else $error("output pins not carrying results");
  property p_sw_c1;
    @(posedge ref_clk) disable iff (!resetn)
      mode == MODE_THREE_MUX |-> pin_ctrl.c1_neg_alt == st_reg.config_r[SWITCH_BIT] && !pin_ctrl.c2_neg_alt;
  endproperty
  a_sw_c1: assert property (p_sw_c1) else $error("switch wrong in three input mode");
  property p_sw_both;
    @(posedge ref_clk) disable iff (!resetn)
      mode == MODE_FOUR_MUX |-> {pin_ctrl.c1_neg_alt, pin_ctrl.c2_neg_alt} == {2{st_reg.config_r[SWITCH_BIT]}};
  endproperty
  a_sw_both: assert property (p_sw_both) else $error("switch wrong in four input mode");
  property p_no_switch;
    @(posedge ref_clk) disable iff (!resetn)
      (mode != MODE_THREE_MUX && mode != MODE_FOUR_MUX) |-> !pin_ctrl.c1_neg_alt && !pin_ctrl.c2_neg_alt;
  endproperty
  a_no_switch: assert property (p_no_switch) else $error("switch active outside its modes");
  property p_sw_analog;
    @(posedge ref_clk) disable iff (!resetn)
      (mode == MODE_THREE_MUX || mode == MODE_FOUR_MUX) |-> pin_ctrl.pin_analog == 4'hf;
  endproperty
  a_sw_analog: assert property (p_sw_analog) else $error("switched pin left analog role");
  property p_gate_comp;
    @(posedge ref_clk) disable iff (!resetn)
      (!st_reg.link[GATE_SEL_BIT] && !st_reg.link[SYNC_BIT]) |=> timer_gate == $past(st_reg.samp_latch[1]);
  endproperty
  a_gate_comp: assert property (p_gate_comp) else $error("gate not from comparator two");
  property p_gate_sync;
    @(posedge ref_clk) disable iff (!resetn)
      (!st_reg.link[GATE_SEL_BIT] && st_reg.link[SYNC_BIT]) |=> timer_gate == $past(st_reg.c2_synced);
  endproperty
  a_gate_sync: assert property (p_gate_sync) else $error("gate not from synced result");
  property p_sync_capture;
    @(posedge ref_clk) disable iff (!resetn)
      (st_reg.tclk_d && !st_reg.tclk_s2) |=> st_reg.c2_synced == $past(st_reg.samp_latch[1]);
  endproperty
  a_sync_capture: assert property (p_sync_capture) else $error("synced result missed falling edge");
  property p_sync_hold;
    @(posedge ref_clk) disable iff (!resetn)
      !(st_reg.tclk_d && !st_reg.tclk_s2) |=> $stable(st_reg.c2_synced);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("synced result moved off edge");
  property p_clear_ok;
    @(posedge ref_clk) disable iff (!resetn)
      (req.wr && req.addr == ADDR_PERIPH_FLAGS && !req.wdata[C1_FLAG_BIT] && !mismatch[0]) |=>
        !st_reg.pflag[C1_FLAG_BIT];
  endproperty
  a_clear_ok: assert property (p_clear_ok) else $error("flag clear ignored");
  property p_link_mask;
    @(posedge ref_clk) disable iff (!resetn)
      1'b1 |-> (st_reg.link & ~LINK_WMASK) == 8'h00;
  endproperty
  a_link_mask: assert property (p_link_mask) else $error("unused link bits set");
  property p_cfg_write;
    @(posedge ref_clk) disable iff (!resetn)
      (req.wr && req.addr == ADDR_CONFIG) |=> (st_reg.config_r & CONFIG_WMASK) == ($past(req.wdata) & CONFIG_WMASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("configuration write lost");
  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!resetn)
      !req.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_rdata_cfg;
    @(posedge ref_clk) disable iff (!resetn)
      (req.rd && req.addr == ADDR_CONFIG) |=> rdata == $past(st_reg.config_r);
  endproperty
  a_rdata_cfg: assert property (p_rdata_cfg) else $error("configuration read wrong");
  property p_one_indep;
    @(posedge ref_clk) disable iff (!resetn)
      mode == MODE_ONE_INDEP |-> pin_ctrl.cmp_on == 2'h2 && !result[0];
  endproperty
  a_one_indep: assert property (p_one_indep) else $error("comparator one on in single mode");

  c_mismatch: cover property (@(posedge ref_clk) disable iff (!resetn) mismatch[0] ##1 cfg_touch);
  c_irq: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(irq));
  c_out_mode: cover property (@(posedge ref_clk) disable iff (!resetn) mode == MODE_COMMON_OUT);
  c_sync: cover property (@(posedge ref_clk) disable iff (!resetn) st_reg.link[SYNC_BIT] && !st_reg.link[GATE_SEL_BIT]);
  c_clear_try: cover property (@(posedge ref_clk) disable iff (!resetn)
    req.wr && req.addr == ADDR_PERIPH_FLAGS && mismatch[1]);
endmodule

// ==== verilog/cmp_ctrl_pkg.sv ====
package cmp_ctrl_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] ADDR_CONFIG = 3'h0;
  localparam logic [2:0] ADDR_TIMER_LINK = 3'h1;
  localparam logic [2:0] ADDR_IRQ_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_PERIPH_ENABLE = 3'h3;
  localparam logic [2:0] ADDR_PERIPH_FLAGS = 3'h4;

  // Reset values.
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_TIMER_LINK = 8'h02;
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH_ENABLE = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;

  // Field positions in the configuration register.
  localparam int MODE_LSB = 0;
  localparam int SWITCH_BIT = 3;
  localparam int INV1_BIT = 4;
  localparam int INV2_BIT = 5;
  localparam int RES1_BIT = 6;
  localparam int RES2_BIT = 7;

  // Field positions in the timer link register.
  localparam int SYNC_BIT = 0;
  localparam int GATE_SEL_BIT = 1;
  localparam logic [7:0] LINK_WMASK = 8'h03;

  // Field positions in the interrupt control and peripheral registers, and the configuration register write mask.
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int C1_FLAG_BIT = 3;
  localparam int C2_FLAG_BIT = 4;
  localparam logic [7:0] CONFIG_WMASK = 8'h3f;

  typedef enum logic [2:0] {
    MODE_OFF_ANALOG = 3'h0,
    MODE_THREE_MUX = 3'h1,
    MODE_FOUR_MUX = 3'h2,
    MODE_COMMON_REF = 3'h3,
    MODE_INDEPENDENT = 3'h4,
    MODE_ONE_INDEP = 3'h5,
    MODE_COMMON_OUT = 3'h6,
    MODE_OFF_DIGITAL = 3'h7
  } cmp_mode_e;

  // Register bus request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Analog front end control and pin roles for the four shared pins:
  // 0 = C1IN-, 1 = C1IN+, 2 = C2IN-, 3 = C2IN+.
  typedef struct packed {
    logic [3:0] pin_analog;
    logic [1:0] out_pin_en;
    logic [1:0] out_pin_val;
    logic [1:0] cmp_on;
    logic c1_neg_alt;
    logic c2_neg_alt;
  } pin_ctrl_s;

  typedef struct packed {
    logic [7:0] config_r;
    logic [7:0] link;
    logic [7:0] irq_ctl;
    logic [7:0] pen;
    logic [7:0] pflag;
    logic [1:0] raw_s1;
    logic [1:0] raw_s2;
    logic [1:0] ref_latch;
    logic [1:0] samp_latch;
    logic gate_s1;
    logic gate_s2;
    logic tclk_s1;
    logic tclk_s2;
    logic tclk_d;
    logic c2_synced;
    logic [7:0] rdata;
    logic irq;
    logic timer_gate;
  } cmp_state_s;

endpackage

// ==== tb/analog_front.sv ====
`timescale 1ns/10ps
// Stand-in for the analog side: two comparator decisions and a free-running timer clock.
module analog_front (
  // Decisions requested by the bench, bit set when the non-inverting input is above
  input wire logic [1:0] pos_above,
  // Towards the block
  output logic [1:0] cmp_raw,
  output logic timer_clk
);
  initial timer_clk = 1'b0;
  // The prescaled timer clock is locked to the system clock, one period every nine system clock cycles.
  always #18 timer_clk = ~timer_clk;
  // The decision settles shortly after the inputs move, never on a clock edge.
  assign #1 cmp_raw = pos_above;
endmodule

// ==== tb/dual_comparator_control_test.sv ====
`timescale 1ns/10ps
module dual_comparator_control_test;
  import cmp_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata;
  logic [1:0] cmp_raw;
  logic [1:0] pos_above = 2'b00;
  pin_ctrl_s pin_ctrl;
  logic [3:0] port_in = 4'h0;
  logic [3:0] port_read;
  logic gate_pin = 1'b0;
  logic timer_clk;
  logic timer_gate;
  logic irq;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'h046a;
  logic [7:0] rst_tab[6] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

  always #2 ref_clk = ~ref_clk;

  analog_front front (.pos_above(pos_above), .cmp_raw(cmp_raw), .timer_clk(timer_clk));

  dual_comparator_control dut (.ref_clk(ref_clk), .resetn(resetn), .req(req), .rdata(rdata),
    .cmp_raw(cmp_raw), .pin_ctrl(pin_ctrl), .port_in(port_in), .port_read(port_read),
    .gate_pin(gate_pin), .timer_clk(timer_clk), .timer_gate(timer_gate), .irq(irq));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    req <= '0;
  endtask

  // The expected value is queued; the watcher below compares it when the data stand.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back(exp);
    @(posedge ref_clk);
    req <= '0;
  endtask

  always @(posedge ref_clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      chk(rdata, e, "read data");
    end
    rd_d <= req.rd;
  end

  task automatic conclude;
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #40000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 6; a++) rd(a[2:0], rst_tab[a]);
    $display("Test reset values done");
    pos_above <= 2'b01;
    wr(ADDR_CONFIG, 8'h04);
    repeat (8) @(posedge ref_clk);
    rd(ADDR_CONFIG, 8'h44);
    wr(ADDR_CONFIG, 8'hf4);
    repeat (8) @(posedge ref_clk);
    rd(ADDR_CONFIG, 8'hb4);
    wr(ADDR_CONFIG, 8'h34);
    repeat (8) @(posedge ref_clk);
    rd(ADDR_CONFIG, 8'hb4);
    $display("Test results and polarity done");
    wr(ADDR_CONFIG, 8'h04);
    repeat (8) @(posedge ref_clk);
    rd(ADDR_CONFIG, 8'h44);
    wr(ADDR_PERIPH_FLAGS, 8'h00);
    rd(ADDR_PERIPH_FLAGS, 8'h00);
    wr(ADDR_PERIPH_ENABLE, 8'h18);
    wr(ADDR_IRQ_CONTROL, 8'hc0);
    pos_above <= 2'b11;
    repeat (8) @(posedge ref_clk);
    chk(irq, 1'b1, "irq after change");
    rd(ADDR_PERIPH_FLAGS, 8'h10);
    wr(ADDR_PERIPH_FLAGS, 8'h00);
    rd(ADDR_PERIPH_FLAGS, 8'h10);
    rd(ADDR_CONFIG, 8'hc4);
    wr(ADDR_PERIPH_FLAGS, 8'h00);
    rd(ADDR_PERIPH_FLAGS, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0, "irq after clear");
    wr(ADDR_PERIPH_FLAGS, 8'h08);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1, "irq after soft set");
    wr(ADDR_IRQ_CONTROL, 8'h40);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0, "irq with global off");
    rd(ADDR_PERIPH_FLAGS, 8'h08);
    $display("Test change flags done");
    // Interrupts stay off while the modes are walked through.
    for (int m = 0; m < 8; m++) begin
      port_in <= $random(seed);
      wr(ADDR_CONFIG, {5'b00000, m[2:0]});
      repeat (3) @(posedge ref_clk);
      chk(pin_ctrl.out_pin_en, (m == 6) ? 2'b11 : 2'b00, "output enables");
      if (m == 6) chk(pin_ctrl.out_pin_val, 2'b11, "output pins");
      if (m == 0) chk(port_read, 4'h0, "analog port read");
      if (m == 0) chk(pin_ctrl.pin_analog, 4'hf, "off analog");
      if (m == 7) chk(port_read, port_in, "digital port read");
    end
    wr(ADDR_CONFIG, 8'h0a);
    repeat (3) @(posedge ref_clk);
    chk(pin_ctrl.pin_analog, 4'hf, "switched pins analog");
    chk(pin_ctrl.c2_neg_alt, 1'b1, "second switch");
    $display("Test modes done");
    wr(ADDR_CONFIG, 8'h04);
    wr(ADDR_TIMER_LINK, 8'h00);
    repeat (8) @(posedge ref_clk);
    chk(timer_gate, 1'b1, "gate from second result");
    pos_above <= 2'b01;
    gate_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(timer_gate, 1'b0, "gate follows second only");
    pos_above <= 2'b11;
    wr(ADDR_TIMER_LINK, 8'h01);
    repeat (24) @(posedge ref_clk);
    chk(timer_gate, 1'b1, "gate from synced result");
    wr(ADDR_TIMER_LINK, 8'hff);
    rd(ADDR_TIMER_LINK, 8'h03);
    wr(ADDR_TIMER_LINK, 8'h02);
    repeat (8) @(posedge ref_clk);
    chk(timer_gate, 1'b1, "gate from pin");
    $display("Test timer gate done");
    repeat (4) @(posedge ref_clk);
    conclude();
  end
endmodule
